/* core/fric_pkg.sv */
`default_nettype none
package fric_pkg;
   // Suspend latency from interrupt request to the erase or program halt, where the acknowledge is given.
   localparam int SUSPEND_LATENCY_NS = 100;
   localparam int CLK_PERIOD_NS = 10;
   localparam int SUSPEND_CYCLES = (SUSPEND_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Fixed wait after a forced abort before interrupt handling may start.
   localparam int ABORT_WAIT_NS = 1000;
   localparam int ABORT_CYCLES = (ABORT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;

   typedef enum logic [2:0] {
      FRIC_IDLE,
      FRIC_BUSY,
      FRIC_SUSPENDING,
      FRIC_SUSPENDED,
      FRIC_ABORT_WAIT
   } fric_state_e;

   typedef struct packed {
      logic start;
      logic is_erase;
      logic flash_mode;
      logic erase_susp_en;
      logic prog_susp_en;
      logic erase_susp_req;
      logic prog_susp_req;
   } fric_ctrl_s;

   typedef struct packed {
      fric_state_e state;
      logic [CNT_W-1:0] cnt;
      logic op_erase;
      logic busy;
      logic suspended;
      logic flash_run;
      logic flash_reset;
      logic irq_ack;
      logic fatal_ack;
      logic aborted;
      logic rd_en;
      logic wr_en;
   } fric_state_s;
endpackage
`default_nettype wire

/* core/fric_ctrl.sv */
`default_nettype none
module fric_ctrl (
   input wire logic sys_clk,
   input wire logic rst,
   input wire fric_pkg::fric_ctrl_s ctrl,
   input wire logic flash_done,
   input wire logic maskable_irq_req,
   input wire logic fatal_irq_req,
   input wire logic parallel_mode,
   input wire logic code_protect,
   input wire logic par_rd_req,
   input wire logic par_wr_req,
   output logic flash_run,
   output logic flash_reset,
   output logic busy,
   output logic suspended,
   output logic irq_ack,
   output logic fatal_ack,
   output logic aborted,
   output logic par_rd_en,
   output logic par_wr_en
);
   fric_pkg::fric_state_s s_reg;
   fric_pkg::fric_state_s s_next;
   logic susp_allowed;

   always_comb begin
      s_next = s_reg;
      s_next.irq_ack = 1'b0;
      s_next.fatal_ack = 1'b0;
      // Suspend is only possible from flash and with the matching enable set.
      susp_allowed = ctrl.flash_mode &&
         (s_reg.op_erase ? ctrl.erase_susp_en : ctrl.prog_susp_en);
      // The array stays untouched when protection is on, whatever is asked.
      s_next.rd_en = parallel_mode && !code_protect && par_rd_req;
      s_next.wr_en = parallel_mode && !code_protect && par_wr_req;
      case (s_reg.state)
         fric_pkg::FRIC_IDLE: begin
            s_next.flash_reset = 1'b0;
            s_next.irq_ack = maskable_irq_req;
            s_next.fatal_ack = fatal_irq_req;
            if (ctrl.start && !fatal_irq_req) begin
               s_next.state = fric_pkg::FRIC_BUSY;
               s_next.op_erase = ctrl.is_erase;
               s_next.busy = 1'b1;
               s_next.flash_run = 1'b1;
               s_next.aborted = 1'b0;
            end
         end
         fric_pkg::FRIC_BUSY: begin
            if (fatal_irq_req) begin
               s_next.state = fric_pkg::FRIC_ABORT_WAIT;
               s_next.flash_run = 1'b0;
               s_next.flash_reset = 1'b1;
               s_next.aborted = 1'b1;
               s_next.cnt = fric_pkg::CNT_RESET;
            end else if (flash_done) begin
               s_next.state = fric_pkg::FRIC_IDLE;
               s_next.busy = 1'b0;
               s_next.flash_run = 1'b0;
               // A pending request is granted once the operation ends.
               s_next.irq_ack = maskable_irq_req;
            end else if (maskable_irq_req && !ctrl.flash_mode) begin
               s_next.irq_ack = 1'b1;
            end else if (maskable_irq_req && susp_allowed) begin
               s_next.state = fric_pkg::FRIC_SUSPENDING;
               s_next.cnt = fric_pkg::CNT_RESET;
            end
         end
         fric_pkg::FRIC_SUSPENDING: begin
            if (fatal_irq_req) begin
               s_next.state = fric_pkg::FRIC_ABORT_WAIT;
               s_next.flash_run = 1'b0;
               s_next.flash_reset = 1'b1;
               s_next.aborted = 1'b1;
               s_next.cnt = fric_pkg::CNT_RESET;
            end else if (flash_done) begin
               // Work that ends inside the latency still counts as finished.
               s_next.state = fric_pkg::FRIC_IDLE;
               s_next.busy = 1'b0;
               s_next.flash_run = 1'b0;
               s_next.irq_ack = maskable_irq_req;
            end else if (s_reg.cnt == 8'(fric_pkg::SUSPEND_CYCLES - 1)) begin
               s_next.state = fric_pkg::FRIC_SUSPENDED;
               s_next.flash_run = 1'b0;
               s_next.suspended = 1'b1;
               s_next.irq_ack = 1'b1;
            end else begin
               s_next.cnt = s_reg.cnt + 8'h01;
            end
         end
         fric_pkg::FRIC_SUSPENDED: begin
            s_next.irq_ack = maskable_irq_req;
            if (fatal_irq_req) begin
               s_next.state = fric_pkg::FRIC_ABORT_WAIT;
               s_next.flash_reset = 1'b1;
               s_next.suspended = 1'b0;
               s_next.aborted = 1'b1;
               s_next.cnt = fric_pkg::CNT_RESET;
            end else if (s_reg.op_erase ? !ctrl.erase_susp_req : !ctrl.prog_susp_req) begin
               s_next.state = fric_pkg::FRIC_BUSY;
               s_next.flash_run = 1'b1;
               s_next.suspended = 1'b0;
            end
         end
         fric_pkg::FRIC_ABORT_WAIT: begin
            // Handling waits until the array has settled after its reset.
            if (s_reg.cnt == 8'(fric_pkg::ABORT_CYCLES - 1)) begin
               s_next.state = fric_pkg::FRIC_IDLE;
               s_next.flash_reset = 1'b0;
               s_next.busy = 1'b0;
               s_next.fatal_ack = 1'b1;
            end else begin
               s_next.cnt = s_reg.cnt + 8'h01;
            end
         end
         default: begin
            s_next.state = fric_pkg::FRIC_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_reg <= '0;
         s_reg.state <= fric_pkg::FRIC_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   assign flash_run = s_reg.flash_run;
   assign flash_reset = s_reg.flash_reset;
   assign busy = s_reg.busy;
   assign suspended = s_reg.suspended;
   assign irq_ack = s_reg.irq_ack;
   assign fatal_ack = s_reg.fatal_ack;
   assign aborted = s_reg.aborted;
   assign par_rd_en = s_reg.rd_en;
   assign par_wr_en = s_reg.wr_en;

   abort_reset_a: assert property (@(posedge sys_clk) disable iff (rst)
      (busy && !flash_reset && fatal_irq_req) |=> (flash_reset && !flash_run))
      else $error("Fatal interrupt did not reset the flash.");
   abort_wait_a: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(flash_reset) |-> (!fatal_ack && flash_reset) [*8])
      else $error("Abort wait ended too early.");
   abort_end_a: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(flash_reset) |-> ##[1:110] fatal_ack)
      else $error("Abort wait never ended.");
   susp_latency_a: assert property (@(posedge sys_clk) disable iff (rst)
      (s_reg.state == fric_pkg::FRIC_BUSY && maskable_irq_req && ctrl.flash_mode &&
      !flash_done && !fatal_irq_req && s_reg.op_erase && ctrl.erase_susp_en)
      |=> ##[9:11] (suspended || flash_reset || !busy))
      else $error("Erase suspend latency not met.");
   prog_latency_a: assert property (@(posedge sys_clk) disable iff (rst)
      (s_reg.state == fric_pkg::FRIC_BUSY && maskable_irq_req && ctrl.flash_mode &&
      !flash_done && !fatal_irq_req && !s_reg.op_erase && ctrl.prog_susp_en)
      |=> ##[9:11] (suspended || flash_reset || !busy))
      else $error("Program suspend latency not met.");
   erase_resume_a: assert property (@(posedge sys_clk) disable iff (rst)
      (suspended && s_reg.op_erase && !ctrl.erase_susp_req && !fatal_irq_req)
      |=> (flash_run && !suspended))
      else $error("Erase did not resume.");
   prog_resume_a: assert property (@(posedge sys_clk) disable iff (rst)
      (suspended && !s_reg.op_erase && !ctrl.prog_susp_req && !fatal_irq_req)
      |=> (flash_run && !suspended))
      else $error("Programming did not resume.");
   no_susp_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
      (flash_run && ctrl.flash_mode && !(s_reg.op_erase ? ctrl.erase_susp_en :
      ctrl.prog_susp_en) && !flash_done) |=> !irq_ack)
      else $error("Interrupt granted during priority operation.");
   ram_grant_a: assert property (@(posedge sys_clk) disable iff (rst)
      (s_reg.state == fric_pkg::FRIC_BUSY && !ctrl.flash_mode && maskable_irq_req &&
      !fatal_irq_req && !flash_done) |=> irq_ack)
      else $error("Maskable interrupt not granted in RAM mode.");
   protect_a: assert property (@(posedge sys_clk) disable iff (rst)
      code_protect |=> !(par_rd_en || par_wr_en))
      else $error("Protected flash accessed in parallel mode.");
   parallel_off_a: assert property (@(posedge sys_clk) disable iff (rst)
      !parallel_mode |=> !(par_rd_en || par_wr_en))
      else $error("Parallel access outside parallel mode.");
   susp_stop_a: assert property (@(posedge sys_clk) disable iff (rst)
      suspended |-> !flash_run)
      else $error("Array runs while suspended.");
   abort_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
      flash_reset |-> (!flash_run && !suspended && aborted))
      else $error("Array active during abort.");
   abort_exit_a: assert property (@(posedge sys_clk) disable iff (rst)
      (flash_reset ##1 !flash_reset) |-> (fatal_ack && !busy))
      else $error("Abort ended without handling start.");
   done_grant_a: assert property (@(posedge sys_clk) disable iff (rst)
      (s_reg.state == fric_pkg::FRIC_BUSY && flash_done && maskable_irq_req &&
      !fatal_irq_req) |=> (irq_ack && !busy))
      else $error("Pending interrupt not granted at end.");
   ram_no_susp_a: assert property (@(posedge sys_clk) disable iff (rst)
      (s_reg.state == fric_pkg::FRIC_BUSY && !ctrl.flash_mode) |=> !suspended)
      else $error("Operation suspended in RAM mode.");
   erase_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
      (suspended && s_reg.op_erase && ctrl.erase_susp_req && !fatal_irq_req)
      |=> suspended)
      else $error("Erase resumed while request set.");
   prog_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
      (suspended && !s_reg.op_erase && ctrl.prog_susp_req && !fatal_irq_req)
      |=> suspended)
      else $error("Programming resumed while request set.");
endmodule
`default_nettype wire

/* bench/fric_flash_model.sv */
`default_nettype none
module fric_flash_model #(
   parameter int OP_CYCLES = 30
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic flash_run,
   input wire logic flash_reset,
   output logic flash_done
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt;
   // Progress only advances while the array runs, so a suspend freezes it.
   always @(posedge sys_clk) begin
      flash_done <= 1'b0;
      if (rst || flash_reset) begin
         cnt <= 0;
      end else if (flash_run) begin
         cnt <= (cnt == OP_CYCLES - 1) ? 0 : cnt + 1;
         flash_done <= (cnt == OP_CYCLES - 1);
      end
   end
endmodule
`default_nettype wire

/* bench/test_fric_ctrl.sv */
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
   $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module test_fric_ctrl;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk, rst, flash_done, irq, fatal, pmode, prot, prd, pwr;
   logic flash_run, flash_reset, busy, suspended, irq_ack, fatal_ack, aborted, rd_en, wr_en;
   fric_pkg::fric_ctrl_s ctrl;
   int fail_count = 0;
   int n_tests = 0;
   int i;
   logic seen;
   fric_ctrl fric_ctrl_i (.sys_clk(sys_clk), .rst(rst), .ctrl(ctrl), .flash_done(flash_done),
      .maskable_irq_req(irq), .fatal_irq_req(fatal), .parallel_mode(pmode),
      .code_protect(prot), .par_rd_req(prd), .par_wr_req(pwr), .flash_run(flash_run),
      .flash_reset(flash_reset), .busy(busy), .suspended(suspended), .irq_ack(irq_ack),
      .fatal_ack(fatal_ack), .aborted(aborted), .par_rd_en(rd_en), .par_wr_en(wr_en));
   fric_flash_model fric_flash_model_i (.sys_clk(sys_clk), .rst(rst), .flash_run(flash_run),
      .flash_reset(flash_reset), .flash_done(flash_done));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task tick(int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task go(logic er, logic fm, logic en);
      ctrl = '0;
      ctrl.is_erase = er;
      ctrl.flash_mode = fm;
      ctrl.erase_susp_en = en;
      ctrl.prog_susp_en = en;
      ctrl.start = 1'b1;
      tick(1);
      ctrl.start = 1'b0;
      tick(2);
   endtask
   task wait_idle();
      for (i = 0; i < 300 && busy !== 1'b0; i++) tick(1);
   endtask
   task close_out();
      $display("counts: %0d compared, %0d mismatched", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      fail_count++;
      close_out();
   end
   initial begin
      {rst, irq, fatal, pmode, prot, prd, pwr} = 7'h7f;
      {irq, fatal, pmode, prot, prd, pwr} = '0;
      ctrl = '0;
      tick(12);
      rst = 1'b0;
      // Both suspend kinds: erase first, then programming.
      for (int k = 1; k >= 0; k--) begin
         go(k[0], 1'b1, 1'b1);
         irq = 1'b1;
         ctrl.erase_susp_req = k[0];
         ctrl.prog_susp_req = !k[0];
         tick(5);
         `CHK(suspended, 1'b0)
         tick(8);
         `CHK({suspended, flash_run, irq_ack}, 3'h5)
         irq = 1'b0;
         ctrl.erase_susp_req = 1'b0;
         ctrl.prog_susp_req = 1'b0;
         tick(3);
         `CHK({suspended, flash_run}, 2'h1)
         wait_idle();
         `CHK({busy, aborted}, 2'h0)
         $display("suspend test done");
      end
      // Suspend disabled: the grant waits for the end of the operation.
      for (int k = 1; k >= 0; k--) begin
         go(k[0], 1'b1, 1'b0);
         irq = 1'b1;
         tick(15);
         `CHK({busy, suspended, irq_ack}, 3'h4)
         wait_idle();
         seen = 1'b0;
         repeat (3) begin
            seen |= irq_ack;
            tick(1);
         end
         `CHK(seen, 1'b1)
         irq = 1'b0;
         tick(3);
      end
      $display("priority test done");
      go(1'b1, 1'b0, 1'b0);
      irq = 1'b1;
      tick(3);
      `CHK({irq_ack, suspended, flash_run}, 3'h5)
      irq = 1'b0;
      wait_idle();
      $display("ram mode test done");
      go(1'b1, 1'b1, 1'b1);
      fatal = 1'b1;
      tick(2);
      fatal = 1'b0;
      `CHK({flash_reset, flash_run, busy, fatal_ack}, 4'ha)
      for (i = 0; i < 150 && fatal_ack !== 1'b1; i++) tick(1);
      `CHK(i > 90, 1'b1)
      `CHK({fatal_ack, aborted}, 2'h3)
      tick(2);
      `CHK({flash_reset, busy}, 2'h0)
      go(1'b1, 1'b1, 1'b1);
      wait_idle();
      `CHK({busy, aborted, flash_reset}, 3'h0)
      $display("abort test done");
      {pmode, prot, prd, pwr} = 4'hf;
      tick(2);
      `CHK({rd_en, wr_en}, 2'h0)
      prot = 1'b0;
      tick(2);
      `CHK({rd_en, wr_en}, 2'h3)
      $display("protect test done");
      close_out();
   end
endmodule
`default_nettype wire
